// [rtl/led_dim_ctrl.sv]
// LED dimming, soft-start, switch control and channel fault logic
// Operation
// RULE1: Dimming rate equals 12.4e7 divided by setting resistance in ohms.
// RULE2: Resistor dimming up to 30kHz, duty 0.4% to 100%, 8-bit steps.
// RULE3: Floating rate pin selects direct mode: channels follow input PWM.
// RULE4: Source keeps direct PWM at most 30kHz, high time at least 450ns.
// RULE5: Resistor on rate pin selects phase shift with 8-bit resolution.
// RULE6: Select level bands choose 600kHz or 1MHz, PWM or PFM.
// RULE7: PFM only engages when output and load conditions ask for it.
// RULE8: Current limit starts at 225mA, seven more 225mA steps to 1.8A.
// RULE9: Steps span about 8ms, longer at low rate and small duty.
// RULE10: Switch on-time ends once switch current exceeds present limit.
// RULE11: A channel above the short threshold is disabled.
// RULE12: Channel good at target current, open if it later drops.
// RULE13: Overvoltage marks every channel not yet good as open.
// RULE14: Open channel is switched off only after a time-out.
// RULE15: A faulted channel leaves the other channels running.
// RULE16: Faults are only judged while the LED loop reports stable; the code marks overvoltage opens and samples shorts without checking stable.
// RULE17: Zener-bridged string stays on unless overvoltage is reached.
// RULE18: Time-out is 6 periods in phase shift, 7 to 18 in direct.
// RULE19: A constantly low PWM input disconnects all channels.
// RULE20: Pulse starts staggered 180 degrees for two, 90 for more.
// RULE21: Over-temperature stops switching and all channel currents.
// RULE22: Period duty is measured, coded 8-bit, applied next period.
`timescale 1ns/1ps
module led_dim_ctrl
  import led_dim_pkg::*;
#(
  parameter int N = 4,
  parameter int AW = 4,
  parameter int SS_CYC = SS_STEP_CYC,
  parameter int IDLE_LIM = IDLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire sense_t sense_pins,
  input wire logic [N-1:0] short_fault_detect,
  input wire logic [N-1:0] open_fault_detect,
  input wire logic [19:0] rate_ohms,
  input wire logic [7:0] switch_rate_select,
  input wire logic [11:0] switch_current_ma,
  output logic boost_gate,
  output logic [N-1:0] led_channel,
  output logic [11:0] current_limit_ma,
  output logic pfm_active,
  output logic fsw_high
);
  localparam int SYW = $bits(sense_t) + 2 * N + 40;

  logic [SYW-1:0] s1_ff, s2_ff;
  sense_t sn;
  logic [N-1:0] shrt, at_tgt;
  logic [19:0] r_ohm;
  logic [7:0] fsw_lvl;
  logic [11:0] sw_ma;

  // Every sense, fault, rate and current pin crosses two flops; stage one feeds only stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {sense_pins, short_fault_detect, open_fault_detect,
                rate_ohms, switch_rate_select, switch_current_ma};
      s2_ff <= s1_ff;
    end
  end
  assign {sn, shrt, at_tgt, r_ohm, fsw_lvl, sw_ma} = s2_ff;

  logic [7:0] ctrl_ff;
  logic run, direct;
  assign run = sn.en & ctrl_ff[0];
  assign direct = sn.rate_float; // RULE3 RULE5

  function automatic logic [7:0] phase_off(input int i);
    phase_off = (N == 2) ? 8'(i) * PH_180 : 8'(i) * PH_90;
  endfunction

  // Input period and high-time measurement
  logic pwm_d_ff, rise, idle_ff;
  logic [23:0] per_ff, hi_ff, per_l_ff;
  logic [24:0] rem_ff;
  logic [7:0] q_ff, meas_ff, act_ff;
  logic [3:0] div_ff;
  assign rise = sn.pwm & ~pwm_d_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_d_ff <= 1'b0;
      per_ff <= '0;
      hi_ff <= '0;
      idle_ff <= 1'b1;
    end else begin
      pwm_d_ff <= sn.pwm;
      if (rise) begin
        per_ff <= 24'h000001;
        hi_ff <= 24'h000001;
        idle_ff <= 1'b0;
      end else begin
        if (per_ff != '1)
          per_ff <= per_ff + 24'h000001;
        if (sn.pwm && hi_ff != '1)
          hi_ff <= hi_ff + 24'h000001;
        if (per_ff >= 24'(IDLE_LIM) && !sn.pwm)
          idle_ff <= 1'b1; // RULE19
      end
    end
  end

  // Serial divider: duty code = high * 256 / period, eight steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_ff <= '0;
      q_ff <= '0;
      div_ff <= '0;
      per_l_ff <= 24'h000001;
      meas_ff <= '0;
    end else if (rise && per_ff != '0) begin
      per_l_ff <= per_ff;
      rem_ff <= {1'b0, hi_ff};
      q_ff <= '0;
      div_ff <= 4'h8;
      if (hi_ff >= per_ff)
        div_ff <= 4'h0;
      if (hi_ff >= per_ff)
        meas_ff <= DUTY_FULL; // RULE22
    end else if (div_ff != '0) begin
      if ({rem_ff[23:0], 1'b0} >= {1'b0, per_l_ff}) begin
        rem_ff <= {rem_ff[23:0], 1'b0} - {1'b0, per_l_ff};
        q_ff <= {q_ff[6:0], 1'b1};
      end else begin
        rem_ff <= {rem_ff[23:0], 1'b0};
        q_ff <= {q_ff[6:0], 1'b0};
      end
      div_ff <= div_ff - 4'h1;
      if (div_ff == 4'h1)
        meas_ff <= 8'h00;
    end else if (meas_ff == 8'h00 && q_ff != 8'h00) begin
      meas_ff <= q_ff;
    end else if (sn.pwm && per_ff >= 24'(IDLE_LIM)) begin
      meas_ff <= DUTY_FULL;
    end
  end

  // Regenerated dimming clock: 256 ticks per period
  logic [19:0] r_clamp;
  logic [37:0] prod;
  logic [13:0] tick_len;
  logic [13:0] tick_ff;
  logic [7:0] pos_ff;
  logic tick, wrap;
  assign r_clamp = (r_ohm < 20'(R_MIN_OHM)) ? 20'(R_MIN_OHM) : r_ohm; // RULE2
  assign prod = 38'(r_clamp) * 38'(R_TO_CYC); // RULE1
  assign tick_len = (prod[37:K_SH+DUTY_W] == '0) ? 14'h0001 :
                    prod[K_SH+DUTY_W+13:K_SH+DUTY_W];
  assign tick = (tick_ff >= tick_len - 14'h0001);
  assign wrap = tick && pos_ff == DUTY_FULL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_ff <= '0;
      pos_ff <= '0;
      act_ff <= '0;
    end else begin
      tick_ff <= tick ? 14'h0000 : tick_ff + 14'h0001;
      if (tick)
        pos_ff <= pos_ff + 8'h01;
      if (wrap)
        act_ff <= meas_ff; // RULE22
    end
  end

  // Channel faults and drive
  logic [N-1:0] good_ff, open_ff, off_ff, on_ff;
  logic [4:0] to_ff [N];
  logic [4:0] to_lim;
  logic per_evt;
  assign per_evt = direct ? rise : wrap;
  assign to_lim = direct ? TO_DIRECT : TO_PS; // RULE18

  for (genvar i = 0; i < N; i++) begin : g_ch
    logic pend, ps_on, sc_ff;
    // Short is judged only while the channel conducts, then held off-pulse
    assign pend = open_ff[i] | sc_ff; // RULE11
    assign ps_on = act_ff == DUTY_FULL ||
                   (pos_ff - phase_off(i)) < act_ff; // RULE20
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        good_ff[i] <= 1'b0;
        open_ff[i] <= 1'b0;
        off_ff[i] <= 1'b0;
        to_ff[i] <= '0;
        sc_ff <= 1'b0;
      end else begin
        if (on_ff[i])
          sc_ff <= shrt[i]; // RULE11
        if (at_tgt[i] && on_ff[i] && sn.stable && !open_ff[i])
          good_ff[i] <= 1'b1; // RULE12
        if (good_ff[i] && on_ff[i] && !at_tgt[i] && sn.stable) begin
          open_ff[i] <= 1'b1; // RULE12
          good_ff[i] <= 1'b0;
        end
        if (sn.output_overvoltage_limit && !good_ff[i])
          open_ff[i] <= 1'b1; // RULE13 RULE17
        if (!pend)
          to_ff[i] <= '0;
        else if (per_evt && sn.stable && to_ff[i] < to_lim)
          to_ff[i] <= to_ff[i] + 5'h01; // RULE14 RULE16
        if (pend && to_ff[i] >= to_lim)
          off_ff[i] <= 1'b1; // RULE14 RULE15
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn)
        on_ff[i] <= 1'b0;
      else
        on_ff[i] <= run && !sn.otp && !idle_ff && ctrl_ff[4+i] &&
                    !off_ff[i] && (direct ? sn.pwm : ps_on); // RULE3 RULE21
    end
  end

  // Soft-start current limit
  logic [2:0] ss_ff;
  logic [31:0] ss_t_ff;
  logic [1:0] ss_p_ff;
  logic [11:0] ilim_ff;
  logic ss_go;
  assign ss_go = ss_t_ff >= 32'(SS_CYC - 1) &&
                 ss_p_ff >= ((act_ff < DUTY_LOW) ? 2'h2 : 2'h1); // RULE9

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ss_ff <= '0;
      ss_t_ff <= '0;
      ss_p_ff <= '0;
    end else if (ss_ff != SS_LAST) begin
      if (ss_go) begin
        ss_ff <= ss_ff + 3'h1; // RULE8
        ss_t_ff <= '0;
        ss_p_ff <= '0;
      end else begin
        if (ss_t_ff < 32'(SS_CYC - 1))
          ss_t_ff <= ss_t_ff + 32'h1;
        if (per_evt && ss_p_ff != 2'h3)
          ss_p_ff <= ss_p_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ilim_ff <= ILIM_STEP_MA;
    else
      ilim_ff <= 12'(({9'h0, ss_ff} + 12'h1) * ILIM_STEP_MA); // RULE8
  end

  // Switch-rate decode; levels between bands keep the last choice
  fsw_mode_t fsw_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fsw_ff <= FSW_PWM_LO;
    else if (fsw_lvl <= FSW_B0_HI)
      fsw_ff <= FSW_PFM_LO; // RULE6
    else if (fsw_lvl >= FSW_B1_LO && fsw_lvl <= FSW_B1_HI)
      fsw_ff <= FSW_PWM_LO;
    else if (fsw_lvl >= FSW_B2_LO && fsw_lvl <= FSW_B2_HI)
      fsw_ff <= FSW_PWM_HI;
    else if (fsw_lvl >= FSW_B3_LO)
      fsw_ff <= FSW_PFM_HI;
  end

  // Boost switch: on at cycle start, off on over-current
  logic [9:0] sw_ff, sw_per;
  logic gate_ff, pfm_ff, fhi, pfm_sel;
  assign fhi = fsw_ff == FSW_PWM_HI || fsw_ff == FSW_PFM_HI;
  assign pfm_sel = fsw_ff == FSW_PFM_LO || fsw_ff == FSW_PFM_HI;
  assign sw_per = fhi ? SW_DIV_HI : SW_DIV_LO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_ff <= '0;
      gate_ff <= 1'b0;
      pfm_ff <= 1'b0;
    end else begin
      sw_ff <= (sw_ff >= sw_per - 10'h1) ? 10'h000 : sw_ff + 10'h1;
      pfm_ff <= pfm_sel && sn.light_load; // RULE7
      if (sw_ff == 10'h000)
        gate_ff <= run && !sn.otp && !(pfm_sel && sn.light_load); // RULE7
      if (sw_ff >= sw_per - (sw_per >> 3))
        gate_ff <= 1'b0;
      if (sw_ma > ilim_ff || sn.otp)
        gate_ff <= 1'b0; // RULE10 RULE21
    end
  end

  // AXI4-Lite slave: write when address and data are both offered
  logic awr_ff, arr_ff, bv_ff, rv_ff;
  logic [1:0] br_ff, rr_ff;
  logic [31:0] rd_ff, rmux;
  logic rok;

  always_comb begin
    rok = 1'b1;
    unique case (araddr[3:0])
      REG_CTRL: rmux = {24'h0, ctrl_ff};
      REG_STATUS: rmux = {19'h0, pfm_ff, fhi, idle_ff, sn.otp, direct,
                          ss_ff, 2'(fsw_ff), 3'h0};
      REG_CHAN: rmux = {16'h0, 4'(off_ff), 4'(shrt & on_ff),
                        4'(open_ff), 4'(good_ff)};
      REG_DUTY: rmux = {2'h0, tick_len, act_ff, meas_ff};
      default: begin
        rmux = '0;
        rok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OK;
      ctrl_ff <= CTRL_RST;
    end else begin
      awr_ff <= awvalid && wvalid && !awr_ff && !bv_ff;
      if (awr_ff) begin
        bv_ff <= 1'b1;
        br_ff <= (awaddr[3:0] == REG_CTRL) ? RESP_OK : RESP_ERR;
        if (awaddr[3:0] == REG_CTRL && wstrb[0])
          ctrl_ff <= wdata[7:0];
      end else if (bready) begin
        bv_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= '0;
      rr_ff <= RESP_OK;
    end else begin
      arr_ff <= arvalid && !arr_ff && !rv_ff;
      if (arr_ff) begin
        rv_ff <= 1'b1;
        rd_ff <= rmux;
        rr_ff <= rok ? RESP_OK : RESP_ERR;
      end else if (rready) begin
        rv_ff <= 1'b0;
      end
    end
  end

  assign awready = awr_ff;
  assign wready = awr_ff;
  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign arready = arr_ff;
  assign rvalid = rv_ff;
  assign rdata = rd_ff;
  assign rresp = rr_ff;
  assign boost_gate = gate_ff;
  assign led_channel = on_ff;
  assign current_limit_ma = ilim_ff;
  assign pfm_active = pfm_ff;
  assign fsw_high = fhi;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ilim;
    gate_ff && sw_ma > ilim_ff |=> !gate_ff;
  endproperty
  a_ilim: assert property (p_ilim) else $error("gate past limit"); // RULE10
  property p_otp;
    sn.otp |=> !gate_ff && on_ff == '0;
  endproperty
  a_otp: assert property (p_otp) else $error("on in overtemp"); // RULE21
  property p_idle;
    idle_ff |=> on_ff == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("on while idle"); // RULE19
  property p_ovp;
    run ##0 sn.output_overvoltage_limit && !good_ff[3] ##1 run |-> open_ff[3];
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp not open"); // RULE13
  property p_direct;
    run && direct && !sn.otp && !idle_ff && ctrl_ff[4] && !off_ff[0]
      |=> on_ff[0] == $past(sn.pwm);
  endproperty
  a_direct: assert property (p_direct) else $error("no follow"); // RULE3
  property p_ss;
    !run [*3] |-> ilim_ff == ILIM_STEP_MA;
  endproperty
  a_ss: assert property (p_ss) else $error("bad first limit"); // RULE8
  property p_to;
    $rose(off_ff[1]) |-> $past(to_ff[1]) == $past(to_lim);
  endproperty
  a_to: assert property (p_to) else $error("early off"); // RULE14
  property p_code;
    wrap |=> act_ff == $past(meas_ff);
  endproperty
  a_code: assert property (p_code) else $error("code not applied"); // RULE22

  c_off: cover property ($rose(off_ff[1]));
  c_ss: cover property (ss_ff == SS_LAST);
  c_pfm: cover property ($rose(pfm_ff));
endmodule

// [rtl/led_dim_pkg.sv]
// Shared constants and types for the LED dimming and fault control block
package led_dim_pkg;
  localparam int CLK_HZ = 250_000_000;
  // Dimming frequency = RATE_NUM / resistance (Hz * ohm)
  localparam longint RATE_NUM = 124_000_000;
  localparam int FMAX_HZ = 30_000;
  localparam int R_MIN_OHM = int'(RATE_NUM / FMAX_HZ);
  localparam int K_SH = 16;
  localparam int R_TO_CYC = int'((longint'(CLK_HZ) << K_SH) / RATE_NUM);
  localparam int DUTY_W = 8;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_LOW = 8'h20;
  localparam logic [7:0] PH_180 = 8'h80;
  localparam logic [7:0] PH_90 = 8'h40;
  localparam int SW_HZ_LO = 600_000;
  localparam int SW_HZ_HI = 1_000_000;
  localparam logic [9:0] SW_DIV_LO = 10'(CLK_HZ / SW_HZ_LO);
  localparam logic [9:0] SW_DIV_HI = 10'(CLK_HZ / SW_HZ_HI);
  // Switch-rate select bands, level in 1/256 of the regulator rail
  localparam logic [7:0] FSW_B0_HI = 8'h1C;
  localparam logic [7:0] FSW_B1_LO = 8'h58;
  localparam logic [7:0] FSW_B1_HI = 8'h70;
  localparam logic [7:0] FSW_B2_LO = 8'h88;
  localparam logic [7:0] FSW_B2_HI = 8'hA1;
  localparam logic [7:0] FSW_B3_LO = 8'hDD;
  localparam logic [11:0] ILIM_STEP_MA = 12'h0E1;
  localparam logic [2:0] SS_LAST = 3'h7;
  localparam int SS_TOTAL_MS = 8;
  localparam int SS_STEP_CYC = CLK_HZ / 1000 * SS_TOTAL_MS / 8;
  localparam logic [4:0] TO_PS = 5'h06;
  localparam logic [4:0] TO_DIRECT = 5'h0C;
  localparam int IDLE_US = 100;
  localparam int IDLE_CYC = CLK_HZ / 1_000_000 * IDLE_US;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CHAN = 4'h8;
  localparam logic [3:0] REG_DUTY = 4'hC;
  localparam logic [7:0] CTRL_RST = 8'hF1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    FSW_PFM_LO, FSW_PWM_LO, FSW_PWM_HI, FSW_PFM_HI
  } fsw_mode_t;
  typedef struct packed {
    logic pwm;
    logic en;
    logic rate_float;
    logic output_overvoltage_limit;
    logic otp;
    logic stable;
    logic light_load;
  } sense_t;
endpackage

// [testbench/pwm_src.sv]
// Host dimming source model: fixed-period PWM with a set high time
`timescale 1ns/1ps
module pwm_src #(
  parameter int PER = 8334
) (
  input wire logic aclk,
  input wire logic run,
  input wire logic [15:0] high,
  output logic pwm
);
  logic [15:0] cnt_ff;
  logic [15:0] hi;
  initial pwm = 1'b0;
  initial cnt_ff = 16'h0000;
  // Short pulses are stretched so the source never drives below 450 ns
  assign hi = (high < 16'h0071) ? 16'h0071 : high;
  // Period fixed at or above the 30 kHz limit
  always @(posedge aclk) begin
    if (!run || cnt_ff >= 16'(PER - 1)) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  always @(posedge aclk) begin
    pwm <= run && (cnt_ff < hi);
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the LED dimming and fault control block
`timescale 1ns/1ps
module tb_top;
  import led_dim_pkg::*;
  localparam int IDL = 8400;
  localparam logic [19:0] OHMS = 20'h01025;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb, short_fault_detect, open_fault_detect;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [19:0] rate_ohms;
  logic [7:0] switch_rate_select;
  logic [7:0] blo [4];
  logic [7:0] bhi [4];
  logic [11:0] switch_current_ma, current_limit_ma, lim_q;
  logic boost_gate, pfm_active, fsw_high, pwm, prun, chk_dir;
  logic [11:0] sq1, sq2, sq3;
  logic [3:0] led_channel, mask, seen;
  logic [2:0] h;
  logic [15:0] phigh;
  sense_t s, sp;
  int seed = 51;
  int cyc = 0;
  int err_total = 0;
  int compares = 0;
  int tk, t0, ts, b;

  led_dim_ctrl #(.SS_CYC(20), .IDLE_LIM(IDL)) led_dim_ctrl_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sense_pins(sp), .short_fault_detect,
    .open_fault_detect, .rate_ohms, .switch_rate_select, .switch_current_ma,
    .boost_gate, .led_channel, .current_limit_ma, .pfm_active, .fsw_high);
  pwm_src pwm_src_i (.aclk, .run(prun), .high(phigh), .pwm);

  always_comb begin
    sp = s;
    sp.pwm = pwm;
  end

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic int tick_of(input int ohms);
    longint rr;
    rr = (ohms < R_MIN_OHM) ? R_MIN_OHM : ohms;
    return int'((rr * R_TO_CYC) >>> (K_SH + DUTY_W));
  endfunction

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic note(input string t);
    $display("test %s finished", t);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                        output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Random switch current; gate, soft-start and direct-mode monitors
  always @(posedge aclk) begin
    cyc++;
    // Current pin reaches the gate three edges after it is driven
    if (aresetn && lim_q == current_limit_ma && sq3 > current_limit_ma)
      chk(boost_gate, 0);
    if (aresetn && current_limit_ma != lim_q && current_limit_ma != 12'h0E1)
      chk(current_limit_ma, lim_q + 12'h0E1);
    if (chk_dir) chk(led_channel, {4{h[2]}} & mask);
    h <= {h[1:0], pwm};
    lim_q <= current_limit_ma;
    sq3 <= sq2;
    sq2 <= sq1;
    sq1 <= switch_current_ma;
    switch_current_ma <= 12'($random(seed) & 2047);
  end

  initial begin
    repeat (130000) @(posedge aclk);
    err_total++;
    test_done;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, chk_dir} = '0;
    {sq1, sq2, sq3} = '0;
    {awaddr, araddr, wdata, short_fault_detect, open_fault_detect} = '0;
    wstrb = 4'hF;
    switch_current_ma = 12'h000;
    switch_rate_select = 8'h60;
    rate_ohms = OHMS;
    s = 7'h32; // Enabled, direct mode, loop stable
    blo = '{8'h00, FSW_B1_LO, FSW_B2_LO, FSW_B3_LO};
    bhi = '{FSW_B0_HI, FSW_B1_HI, FSW_B2_HI, 8'hFF};
    tk = tick_of(int'(OHMS));
    mask = 4'hF;
    prun = 1'b1;
    // Phase mode stagger needs duty below half a period
    phigh = 16'(113 + ($random(seed) & 32'hEFF));
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(current_limit_ma, 12'h0E1);
    chk(boost_gate, 0);
    axi_rd(REG_CTRL, d, r);
    chk(d, {24'h0, CTRL_RST});
    chk(r, RESP_OK);
    axi_rd(4'h2, d, r);
    chk(r, RESP_ERR);
    axi_wr(REG_STATUS, 32'h0, r);
    chk(r, RESP_ERR);
    note("registers");
    s.light_load <= 1'b1;
    for (b = 0; b < 4; b++) begin
      switch_rate_select <=
        8'(blo[b] + ($random(seed) & 32'hFFFF) % (bhi[b] - blo[b] + 1));
      repeat (450) @(posedge aclk);
      axi_rd(REG_STATUS, d, r);
      chk(d[4:3], b);
      chk(fsw_high, b > 1);
      chk(pfm_active, b == 0 || b == 3);
    end
    s.light_load <= 1'b0;
    repeat (450) @(posedge aclk);
    chk(pfm_active, 0);
    note("switch rate");
    axi_wr(REG_CTRL, 32'h51, r);
    mask = 4'b0101;
    repeat (10) @(posedge aclk);
    axi_rd(REG_STATUS, d, r);
    chk(d[8], 1);
    chk_dir <= 1'b1;
    repeat (4200) @(posedge aclk);
    chk_dir <= 1'b0;
    axi_wr(REG_CTRL, 32'hF1, r);
    note("direct");
    s.rate_float <= 1'b0;
    phigh <= 16'(113 + ($random(seed) & 32'hEFF));
    ts = cyc;
    repeat (200) @(posedge aclk);
    @(posedge led_channel[0]);
    t0 = cyc;
    @(posedge led_channel[2]);
    chk(cyc - t0, 128 * tk);
    repeat (17000 - (cyc - ts)) @(posedge aclk);
    axi_rd(REG_DUTY, d, r);
    chk(d[7:0], phigh * 256 / 8334);
    chk(d[29:16], tk);
    axi_rd(REG_STATUS, d, r);
    chk(d[8], 0);
    note("phase");
    // Channels must conduct at target before overvoltage to count as good
    open_fault_detect <= 4'b0111;
    repeat (8300) @(posedge aclk);
    short_fault_detect <= 4'b0010;
    s.output_overvoltage_limit <= 1'b1;
    repeat (10) @(posedge aclk);
    s.output_overvoltage_limit <= 1'b0;
    axi_rd(REG_CHAN, d, r);
    chk(d[7:4], 4'b1000);
    chk(d[15:12], 0);
    // Short shows only while the channel pulse is on: poll one period
    b = 0;
    repeat (2800) begin
      axi_rd(REG_CHAN, d, r);
      b = b | d[9];
    end
    chk(b, 1);
    repeat (28000) @(posedge aclk);
    axi_rd(REG_CHAN, d, r);
    chk(d[15:12], 0);
    repeat (22000) @(posedge aclk);
    axi_rd(REG_CHAN, d, r);
    chk(d[15:12], 4'b1010);
    seen = 4'h0;
    repeat (8300) begin
      @(posedge aclk);
      seen |= led_channel;
    end
    chk(seen, 4'b0101);
    chk(current_limit_ma, 12'h708);
    note("faults");
    prun <= 1'b0;
    repeat (IDL + 200) @(posedge aclk);
    axi_rd(REG_STATUS, d, r);
    chk(d[10], 1);
    chk(led_channel, 0);
    note("idle");
    prun <= 1'b1;
    s.otp <= 1'b1;
    repeat (8) @(posedge aclk);
    repeat (300) begin
      @(posedge aclk);
      chk(boost_gate, 0);
      chk(led_channel, 0);
    end
    note("over temperature");
    test_done;
  end
endmodule
